//--- include/fast_timer_pkg.sv
package fast_timer_pkg;
	// register addresses
	localparam logic [7:0] ADDR_PLL = 8'h29;
	localparam logic [7:0] ADDR_TOP = 8'h2b;
	localparam logic [7:0] ADDR_CMP_B = 8'h2c;
	localparam logic [7:0] ADDR_CMP_A = 8'h2d;
	localparam logic [7:0] ADDR_COUNT = 8'h2e;
	localparam logic [7:0] ADDR_CTRL_B = 8'h2f;
	localparam logic [7:0] ADDR_CTRL_A = 8'h30;
	localparam logic [7:0] ADDR_FLAGS = 8'h38;
	// timer_control_a fields
	localparam int MODE_A_LSB = 6;
	localparam int MODE_B_LSB = 4;
	localparam int FORCE_A = 3;
	localparam int FORCE_B = 2;
	localparam int PWM_A = 1;
	localparam int PWM_B = 0;
	// timer_control_b fields
	localparam int CTC = 7;
	localparam int PSC_CLR = 6;
	localparam int CS_LSB = 0;
	localparam int CS_W = 4;
	// pll_control_status fields
	localparam int FAST_CLOCK_ENABLE = 2;
	localparam int PLL_ENABLE = 1;
	localparam int PLL_LOCK_INDICATOR = 0;
	// flag register fields
	localparam int FLAG_A = 0;
	localparam int FLAG_B = 1;
	localparam int FLAG_OVF = 2;
	// reset values
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [3:0] CS_RST = 4'h0;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	// timing
	localparam int PSC_W = 14;
	localparam int CLK_MHZ = 200;
	localparam int PLL_LOCK_US = 100;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;
	typedef enum logic [1:0] {MODE_OFF, MODE_TOGGLE, MODE_CLEAR, MODE_SET} out_mode_t;
endpackage : fast_timer_pkg

//--- src/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : sync_2ff

//--- src/fast_timer_with_pll_clock.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - channel b mode: 00 off, 01 toggle, 10 low, 11 high on match
// - force a applies channel a action as a match, same-cycle mode used
// - force b applies channel b action as a match, same-cycle mode used
// - force bits read zero; force ignored while that channel pwm set
// - pwm a enable: pwm mode, counter cleared cycle after top match
// - pwm b enable: pwm mode, counter cleared cycle after top match
// - clear-on-top set clears counter cycle after top match
// - prescaler clear write one resets prescaler, reads zero
// - clock select zero stops; code n divides by two to n-1
// - counter write lands after one cycle sync, two at most async
// - match only when counter counts to value, not by a write
// - match a or b sets its flag after a sync delay
// - top match with clear-on-top clears counter and sets overflow flag
// - fast clock enable selects fast clock, else system clock
// - fast clock enable only accepted while pll enable set
// - pll enable starts pll; reads one when pll is system clock
// - lock indicator reads one once pll locked after enable
// - pwm output and complement never high together, rising edges delayed
// - pwm compare writes held until top, reads give last written
// - overflow flag on wrap from ff or from top to zero
module fast_timer_with_pll_clock #(
	parameter int LOCK_CYCLES = fast_timer_pkg::PLL_LOCK_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic fast_peripheral_clock,
	input wire logic pll_as_system_clock,
	output logic pll_start,
	output logic compare_out_a,
	output logic compare_out_a_oe,
	output logic compare_out_a_n,
	output logic compare_out_a_n_oe,
	output logic compare_out_b,
	output logic compare_out_b_oe,
	output logic compare_out_b_n,
	output logic compare_out_b_n_oe,
	output logic match_a_flag,
	output logic match_b_flag,
	output logic overflow_flag
);
	if (LOCK_CYCLES < 1) begin : g_bad_lock
		$error("LOCK_CYCLES must be at least one");
	end

	localparam int LW = $clog2(LOCK_CYCLES + 1);
	localparam int PW = fast_timer_pkg::PSC_W;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and decode
	logic [1:0] pins_s;
	logic pck_s;
	logic sys_s;
	logic wr_a;
	logic wr_b;
	logic wr_pll;
	logic wr_cnt;
	logic wr_top;
	logic wr_flags;
	logic [1:0] wr_cmp;
	logic psc_clr;

	sync_2ff #(.W(2)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.d({pll_as_system_clock, fast_peripheral_clock}),
		.q(pins_s)
	);
	assign pck_s = pins_s[0];
	assign sys_s = pins_s[1];

	assign wr_a = reg_wr && reg_addr == fast_timer_pkg::ADDR_CTRL_A;
	assign wr_b = reg_wr && reg_addr == fast_timer_pkg::ADDR_CTRL_B;
	assign wr_pll = reg_wr && reg_addr == fast_timer_pkg::ADDR_PLL;
	assign wr_cnt = reg_wr && reg_addr == fast_timer_pkg::ADDR_COUNT;
	assign wr_top = reg_wr && reg_addr == fast_timer_pkg::ADDR_TOP;
	assign wr_flags = reg_wr && reg_addr == fast_timer_pkg::ADDR_FLAGS;
	assign wr_cmp[0] = reg_wr && reg_addr == fast_timer_pkg::ADDR_CMP_A;
	assign wr_cmp[1] = reg_wr && reg_addr == fast_timer_pkg::ADDR_CMP_B;
	assign psc_clr = wr_b && reg_wdata[fast_timer_pkg::PSC_CLR];

	////////////////////////////////////////////////////////////////////////
	// configuration, pll and read back
	logic [7:0] ctrl_a_reg, ctrl_a_next;
	logic ctc_reg, ctc_next;
	logic [3:0] cs_reg, cs_next;
	logic fast_clock_enable_reg, fast_clock_enable_next;
	logic pll_enable_reg, pll_enable_next;
	logic lock_reg, lock_next;
	logic [LW-1:0] lock_cnt_reg, lock_cnt_next;
	logic pll_start_reg, pll_start_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [2:0] flags_reg, flags_next;
	logic [2:0] ev_d2_reg;
	logic [7:0] count_reg;
	logic [1:0][7:0] hold_reg;
	logic [7:0] top_reg;
	logic pll_enable_eff;

	assign pll_enable_eff = pll_enable_reg | sys_s;

	always_comb begin
		ctrl_a_next = ctrl_a_reg;
		ctc_next = ctc_reg;
		cs_next = cs_reg;
		pll_enable_next = pll_enable_reg;
		fast_clock_enable_next = fast_clock_enable_reg;
		if (wr_a) begin
			ctrl_a_next = reg_wdata;
			ctrl_a_next[fast_timer_pkg::FORCE_A] = 1'b0;
			ctrl_a_next[fast_timer_pkg::FORCE_B] = 1'b0;
		end
		if (wr_b) begin
			ctc_next = reg_wdata[fast_timer_pkg::CTC];
			cs_next = reg_wdata[fast_timer_pkg::CS_LSB +: fast_timer_pkg::CS_W];
		end
		if (wr_pll) begin
			pll_enable_next = reg_wdata[fast_timer_pkg::PLL_ENABLE];
			fast_clock_enable_next = reg_wdata[fast_timer_pkg::FAST_CLOCK_ENABLE];
		end
		if (!(pll_enable_next || sys_s)) begin
			fast_clock_enable_next = 1'b0;
		end
		pll_start_next = pll_enable_next | sys_s;
		lock_cnt_next = lock_cnt_reg;
		lock_next = lock_reg;
		if (!pll_enable_eff) begin
			lock_cnt_next = '0;
			lock_next = 1'b0;
		end else if (lock_cnt_reg == LW'(LOCK_CYCLES)) begin
			lock_next = 1'b1;
		end else begin
			lock_cnt_next = lock_cnt_reg + LW'(1);
		end
		// flags set, set wins over clear
		flags_next = flags_reg;
		if (wr_flags) begin
			flags_next = flags_reg & ~reg_wdata[2:0];
		end
		flags_next = flags_next | ev_d2_reg;
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				fast_timer_pkg::ADDR_CTRL_A: rdata_next = ctrl_a_reg;
				fast_timer_pkg::ADDR_CTRL_B: begin
					rdata_next[fast_timer_pkg::CTC] = ctc_reg;
					rdata_next[fast_timer_pkg::CS_LSB +: fast_timer_pkg::CS_W] = cs_reg;
				end
				fast_timer_pkg::ADDR_PLL: begin
					rdata_next[fast_timer_pkg::FAST_CLOCK_ENABLE] = fast_clock_enable_reg;
					// reads one when pll clocks the system
					rdata_next[fast_timer_pkg::PLL_ENABLE] = pll_enable_eff;
					rdata_next[fast_timer_pkg::PLL_LOCK_INDICATOR] = lock_reg;
				end
				fast_timer_pkg::ADDR_COUNT: rdata_next = count_reg;
				fast_timer_pkg::ADDR_CMP_A: rdata_next = hold_reg[0];
				fast_timer_pkg::ADDR_CMP_B: rdata_next = hold_reg[1];
				fast_timer_pkg::ADDR_TOP: rdata_next = top_reg;
				fast_timer_pkg::ADDR_FLAGS: rdata_next = {5'h00, flags_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_a_reg <= fast_timer_pkg::CTRL_A_RST;
			ctc_reg <= 1'b0;
			cs_reg <= fast_timer_pkg::CS_RST;
			pll_enable_reg <= 1'b0;
			fast_clock_enable_reg <= 1'b0;
			lock_reg <= 1'b0;
			lock_cnt_reg <= '0;
			pll_start_reg <= 1'b0;
			flags_reg <= fast_timer_pkg::FLAGS_RST;
			rdata_reg <= 8'h00;
		end else begin
			ctrl_a_reg <= ctrl_a_next;
			ctc_reg <= ctc_next;
			cs_reg <= cs_next;
			pll_enable_reg <= pll_enable_next;
			fast_clock_enable_reg <= fast_clock_enable_next;
			lock_reg <= lock_next;
			lock_cnt_reg <= lock_cnt_next;
			pll_start_reg <= pll_start_next;
			flags_reg <= flags_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign pll_start = pll_start_reg;
	assign match_a_flag = flags_reg[fast_timer_pkg::FLAG_A];
	assign match_b_flag = flags_reg[fast_timer_pkg::FLAG_B];
	assign overflow_flag = flags_reg[fast_timer_pkg::FLAG_OVF];

	////////////////////////////////////////////////////////////////////////
	// prescaler and counter
	logic [PW-1:0] psc_reg, psc_next;
	logic [7:0] count_next;
	logic step_reg, step_next;
	logic pend_reg, pend_next;
	logic [7:0] pend_val_reg, pend_val_next;
	logic pck_prev_reg;
	logic [1:0][7:0] act_reg, act_next;
	logic [1:0][7:0] hold_next;
	logic [7:0] top_next;
	logic [2:0] ev;
	logic [2:0] ev_d1_reg;
	logic [PW:0] one_sh;
	logic [PW-1:0] mask;
	logic tick;
	logic count_en;
	logic clr_mode;
	logic top_clr;
	logic [1:0] match;
	logic [1:0] pwm;

	assign pwm[0] = ctrl_a_reg[fast_timer_pkg::PWM_A];
	assign pwm[1] = ctrl_a_reg[fast_timer_pkg::PWM_B];
	// fast clock edge or every system cycle
	assign tick = fast_clock_enable_reg ? (pck_s & ~pck_prev_reg) : 1'b1;
	// divide by two to the code minus one
	assign one_sh = (PW + 1)'(1) << (cs_reg - 4'd1);
	assign mask = PW'(one_sh - (PW + 1)'(1));
	assign count_en = tick && cs_reg != 4'h0 && (psc_reg & mask) == mask;
	assign clr_mode = ctc_reg | pwm[0] | pwm[1];
	// match only after a count step
	assign top_clr = clr_mode && step_reg && count_reg == top_reg;
	assign match[0] = step_reg && count_reg == act_reg[0];
	assign match[1] = step_reg && count_reg == act_reg[1];

	always_comb begin
		psc_next = psc_reg;
		if (psc_clr) begin
			psc_next = '0;
		end else if (tick && cs_reg != 4'h0) begin
			psc_next = psc_reg + PW'(1);
		end
		count_next = count_reg;
		step_next = 1'b0;
		pend_next = 1'b0;
		pend_val_next = pend_val_reg;
		ev = 3'h0;
		ev[fast_timer_pkg::FLAG_A] = match[0];
		ev[fast_timer_pkg::FLAG_B] = match[1];
		// direct in sync mode, one stage more in async mode
		if (wr_cnt && !fast_clock_enable_reg) begin
			count_next = reg_wdata;
		end else if (wr_cnt) begin
			pend_next = 1'b1;
			pend_val_next = reg_wdata;
		end else if (pend_reg) begin
			count_next = pend_val_reg;
		end else if (top_clr) begin
			count_next = 8'h00;
			step_next = 1'b1;
			ev[fast_timer_pkg::FLAG_OVF] = 1'b1;
		end else if (count_en) begin
			count_next = count_reg + 8'd1;
			step_next = 1'b1;
			ev[fast_timer_pkg::FLAG_OVF] = count_reg == 8'hff;
		end
		act_next = act_reg;
		hold_next = hold_reg;
		for (int i = 0; i < 2; i++) begin
			if (top_clr && pwm[i]) begin
				act_next[i] = hold_reg[i];
			end
			if (wr_cmp[i]) begin
				hold_next[i] = reg_wdata;
				if (!pwm[i]) begin
					act_next[i] = reg_wdata;
				end
			end
		end
		top_next = wr_top ? reg_wdata : top_reg;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			psc_reg <= '0;
			count_reg <= fast_timer_pkg::COUNT_RST;
			step_reg <= 1'b0;
			pend_reg <= 1'b0;
			pend_val_reg <= 8'h00;
			pck_prev_reg <= 1'b0;
			act_reg <= {2{fast_timer_pkg::CMP_RST}};
			hold_reg <= {2{fast_timer_pkg::CMP_RST}};
			top_reg <= fast_timer_pkg::CMP_RST;
			ev_d1_reg <= 3'h0;
			ev_d2_reg <= 3'h0;
		end else begin
			psc_reg <= psc_next;
			count_reg <= count_next;
			step_reg <= step_next;
			pend_reg <= pend_next;
			pend_val_reg <= pend_val_next;
			pck_prev_reg <= pck_s;
			act_reg <= act_next;
			hold_reg <= hold_next;
			top_reg <= top_next;
			ev_d1_reg <= ev;
			ev_d2_reg <= ev_d1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare output channels, 0 is a, 1 is b
	for (genvar i = 0; i < 2; i++) begin : g_ch
		localparam int ML = (i == 0) ? fast_timer_pkg::MODE_A_LSB : fast_timer_pkg::MODE_B_LSB;
		localparam int FB = (i == 0) ? fast_timer_pkg::FORCE_A : fast_timer_pkg::FORCE_B;
		localparam int PB = (i == 0) ? fast_timer_pkg::PWM_A : fast_timer_pkg::PWM_B;
		logic force_hit;
		logic pos;
		logic neg;
		fast_timer_pkg::out_mode_t mode;
		logic lvl_reg, lvl_next;
		logic raw_reg, raw_next;
		logic rprev_reg, rprev_next;
		logic out_reg, out_next;
		logic oe_reg, oe_next;
		logic outn_reg, outn_next;
		logic oen_reg, oen_next;

		assign force_hit = wr_a && reg_wdata[FB] && !reg_wdata[PB];
		assign mode = fast_timer_pkg::out_mode_t'(force_hit ? reg_wdata[ML +: 2]
			: ctrl_a_reg[ML +: 2]);
		assign pos = raw_reg & rprev_reg;
		assign neg = ~raw_reg & ~rprev_reg;

		always_comb begin
			lvl_next = lvl_reg;
			if (force_hit || (match[i] && !pwm[i])) begin
				case (mode)
					fast_timer_pkg::MODE_TOGGLE: lvl_next = ~lvl_reg;
					fast_timer_pkg::MODE_CLEAR: lvl_next = 1'b0;
					fast_timer_pkg::MODE_SET: lvl_next = 1'b1;
					default: lvl_next = lvl_reg;
				endcase
			end
			raw_next = raw_reg;
			if (top_clr) begin
				raw_next = 1'b1;
			end else if (match[i]) begin
				raw_next = 1'b0;
			end
			// rising edges wait one prescaled cycle
			rprev_next = count_en ? raw_reg : rprev_reg;
			out_next = lvl_reg;
			outn_next = 1'b0;
			oen_next = 1'b0;
			oe_next = mode != fast_timer_pkg::MODE_OFF;
			if (pwm[i]) begin
				case (mode)
					fast_timer_pkg::MODE_TOGGLE: begin
						out_next = pos;
						outn_next = neg;
						oen_next = 1'b1;
					end
					fast_timer_pkg::MODE_CLEAR: out_next = pos;
					fast_timer_pkg::MODE_SET: out_next = neg;
					default: out_next = 1'b0;
				endcase
			end
		end

		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				lvl_reg <= 1'b0;
				raw_reg <= 1'b0;
				rprev_reg <= 1'b0;
				out_reg <= 1'b0;
				oe_reg <= 1'b0;
				outn_reg <= 1'b0;
				oen_reg <= 1'b0;
			end else begin
				lvl_reg <= lvl_next;
				raw_reg <= raw_next;
				rprev_reg <= rprev_next;
				out_reg <= out_next;
				oe_reg <= oe_next;
				outn_reg <= outn_next;
				oen_reg <= oen_next;
			end
		end
	end

	assign compare_out_a = g_ch[0].out_reg;
	assign compare_out_a_oe = g_ch[0].oe_reg;
	assign compare_out_a_n = g_ch[0].outn_reg;
	assign compare_out_a_n_oe = g_ch[0].oen_reg;
	assign compare_out_b = g_ch[1].out_reg;
	assign compare_out_b_oe = g_ch[1].oe_reg;
	assign compare_out_b_n = g_ch[1].outn_reg;
	assign compare_out_b_n_oe = g_ch[1].oen_reg;
endmodule : fast_timer_with_pll_clock

//--- tb/fast_timer_checker.sv
`timescale 1ns/1ps
module fast_timer_checker #(
	parameter int LOCK_CYCLES = 20
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic pll_as_system_clock,
	input wire logic pll_start,
	input wire logic compare_out_a,
	input wire logic compare_out_a_n,
	input wire logic compare_out_b,
	input wire logic compare_out_b_n,
	input wire logic compare_out_b_oe,
	input wire logic match_a_flag
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence rd_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	sequence ctrl_a_wr;
		reg_wr && reg_addr == fast_timer_pkg::ADDR_CTRL_A;
	endsequence
	////////////////////////////////////////////////////////////////////////
	force_zero_a:
		assert property (rd_at(fast_timer_pkg::ADDR_CTRL_A) |=> reg_rdata[3:2] == 2'b00)
		else $error("force bits read nonzero");
	psc_zero_a:
		assert property (rd_at(fast_timer_pkg::ADDR_CTRL_B) |=> reg_rdata[6:4] == 3'h0)
		else $error("prescaler clear bit reads nonzero");
	fast_gate_a:
		assert property (rd_at(fast_timer_pkg::ADDR_PLL) |=> !reg_rdata[2] || reg_rdata[1])
		else $error("fast clock enable set without pll enable");
	strap_pll_a:
		assert property (pll_as_system_clock [*4] |-> pll_start)
		else $error("pll off while strap high");
	pair_a_apart_a:
		assert property (!(compare_out_a && compare_out_a_n))
		else $error("channel a pair high together");
	pair_b_apart_a:
		assert property (!(compare_out_b && compare_out_b_n))
		else $error("channel b pair high together");
	flag_hold_a:
		assert property (match_a_flag && !(reg_wr && reg_addr == fast_timer_pkg::ADDR_FLAGS
			&& reg_wdata[0]) |=> match_a_flag)
		else $error("match a flag dropped");
	out_b_off_a:
		assert property (ctrl_a_wr ##0 reg_wdata[5:4] == 2'b00 ##1 !reg_wr |=> !compare_out_b_oe)
		else $error("channel b driven with mode off");
	force_b_set_a:
		assert property (ctrl_a_wr ##0 (reg_wdata[5:4] == 2'b11 && reg_wdata[2] && !reg_wdata[0])
			|-> ##[1:3] compare_out_b)
		else $error("force b set mode not applied");
	force_a_clr_a:
		assert property (ctrl_a_wr ##0 (reg_wdata[7:6] == 2'b10 && reg_wdata[3] && !reg_wdata[1])
			|-> ##[1:3] !compare_out_a)
		else $error("force a clear mode not applied");
endmodule : fast_timer_checker

bind fast_timer_with_pll_clock fast_timer_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.*);

//--- tb/timer_load_model.sv
`timescale 1ns/1ps
module timer_load_model (
	input wire logic pll_start,
	input wire logic compare_out_a,
	input wire logic compare_out_a_oe,
	input wire logic compare_out_b,
	input wire logic compare_out_b_oe,
	output logic fast_peripheral_clock,
	output logic pin_a,
	output logic pin_b
);
	initial fast_peripheral_clock = 1'b0;
	// 64 mhz source, still while the pll is off
	always #7.8125 fast_peripheral_clock = pll_start ? !fast_peripheral_clock : 1'b0;
	assign pin_a = compare_out_a_oe ? compare_out_a : 1'b0;
	assign pin_b = compare_out_b_oe ? compare_out_b : 1'b0;
endmodule : timer_load_model

//--- tb/fast_timer_with_pll_clock_tb_top.sv
`timescale 1ns/1ps
module fast_timer_with_pll_clock_tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pll_as_system_clock = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] v;
	logic fast_peripheral_clock, pll_start, pin_a, pin_b;
	logic compare_out_a, compare_out_a_oe, compare_out_b, compare_out_b_oe;
	logic match_a_flag, match_b_flag, overflow_flag;
	logic [1:0] modes [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
	logic pins [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int mismatches = 0;
	int cmp_count = 0;
	always #2.5 core_clk = ~core_clk;
	fast_timer_with_pll_clock #(.LOCK_CYCLES(20)) u_dut (.core_clk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fast_peripheral_clock, .pll_as_system_clock,
		.pll_start, .compare_out_a, .compare_out_a_oe, .compare_out_a_n(), .compare_out_a_n_oe(),
		.compare_out_b, .compare_out_b_oe, .compare_out_b_n(), .compare_out_b_n_oe(),
		.match_a_flag, .match_b_flag, .overflow_flag);
	timer_load_model u_load (.pll_start, .compare_out_a, .compare_out_a_oe, .compare_out_b,
		.compare_out_b_oe, .fast_peripheral_clock, .pin_a, .pin_b);
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(v, exp);
	endtask : rdchk
	function automatic logic [7:0] inr(input logic [7:0] x, input int lo, input int hi);
		return 8'(x >= lo && x <= hi);
	endfunction : inr
	task automatic run(input logic [7:0] cs, input int n);
		wr(fast_timer_pkg::ADDR_CTRL_B, cs);
		repeat (n) @(posedge core_clk);
		wr(fast_timer_pkg::ADDR_CTRL_B, cs & 8'h80);
		rd(fast_timer_pkg::ADDR_COUNT);
	endtask : run
	task automatic summarize();
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	initial begin
		#40us;
		mismatches++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdchk(fast_timer_pkg::ADDR_CTRL_A, 8'h00);
		rdchk(fast_timer_pkg::ADDR_CTRL_B, 8'h00);
		rdchk(fast_timer_pkg::ADDR_PLL, 8'h00);
		foreach (modes[i]) begin
			wr(fast_timer_pkg::ADDR_CTRL_A, {modes[i], modes[i], 4'hc});
			repeat (3) @(posedge core_clk);
			chk({pin_a, pin_b, compare_out_a_oe, compare_out_b_oe},
				{pins[i], pins[i], {2{modes[i] != 2'h0}}});
			rdchk(fast_timer_pkg::ADDR_CTRL_A, {modes[i], modes[i], 4'h0});
		end
		wr(fast_timer_pkg::ADDR_CMP_A, 8'h5a);
		rdchk(fast_timer_pkg::ADDR_CMP_A, 8'h5a);
		wr(fast_timer_pkg::ADDR_CTRL_B, 8'hf0);
		rdchk(fast_timer_pkg::ADDR_CTRL_B, 8'h80);
		rdchk(8'h31, 8'h00);
		for (int k = 1; k <= 4; k++) begin
			wr(fast_timer_pkg::ADDR_CTRL_B, 8'h40);
			wr(fast_timer_pkg::ADDR_COUNT, 8'h00);
			run(8'(k), 64);
			chk(inr(v, (66 >> (k - 1)) - 2, (66 >> (k - 1)) + 2), 8'h01);
			rdchk(fast_timer_pkg::ADDR_COUNT, v);
		end
		wr(fast_timer_pkg::ADDR_CMP_B, 8'h40);
		wr(fast_timer_pkg::ADDR_FLAGS, 8'h07);
		wr(fast_timer_pkg::ADDR_COUNT, 8'h40);
		repeat (8) @(posedge core_clk);
		chk({7'h0, match_b_flag}, 8'h00);
		rdchk(fast_timer_pkg::ADDR_COUNT, 8'h40);
		wr(fast_timer_pkg::ADDR_TOP, 8'h09);
		wr(fast_timer_pkg::ADDR_CMP_A, 8'h05);
		wr(fast_timer_pkg::ADDR_COUNT, 8'h00);
		wr(fast_timer_pkg::ADDR_FLAGS, 8'h07);
		run(8'h81, 40);
		chk(inr(v, 0, 9), 8'h01);
		chk({match_a_flag, match_b_flag, overflow_flag}, 8'h05);
		wr(fast_timer_pkg::ADDR_FLAGS, 8'h07);
		repeat (2) @(posedge core_clk);
		chk({match_a_flag, match_b_flag, overflow_flag}, 8'h00);
		wr(fast_timer_pkg::ADDR_COUNT, 8'h00);
		run(8'h01, 30);
		chk(inr(v, 20, 40), 8'h01);
		wr(fast_timer_pkg::ADDR_FLAGS, 8'h07);
		wr(fast_timer_pkg::ADDR_COUNT, 8'hfe);
		run(8'h01, 4);
		chk({7'h0, overflow_flag}, 8'h01);
		for (int k = 0; k < 2; k++) begin
			wr(fast_timer_pkg::ADDR_CTRL_A, k ? 8'h11 : 8'h42);
			wr(fast_timer_pkg::ADDR_COUNT, 8'h00);
			run(8'h01, 40);
			chk(inr(v, 0, 9), 8'h01);
		end
		wr(fast_timer_pkg::ADDR_CTRL_A, 8'h00);
		wr(fast_timer_pkg::ADDR_PLL, 8'h04);
		rdchk(fast_timer_pkg::ADDR_PLL, 8'h00);
		wr(fast_timer_pkg::ADDR_PLL, 8'h02);
		rdchk(fast_timer_pkg::ADDR_PLL, 8'h02);
		chk({7'h0, pll_start}, 8'h01);
		repeat (30) @(posedge core_clk);
		rdchk(fast_timer_pkg::ADDR_PLL, 8'h03);
		wr(fast_timer_pkg::ADDR_PLL, 8'h06);
		rdchk(fast_timer_pkg::ADDR_PLL, 8'h07);
		wr(fast_timer_pkg::ADDR_COUNT, 8'h33);
		repeat (3) @(posedge core_clk);
		rdchk(fast_timer_pkg::ADDR_COUNT, 8'h33);
		run(8'h01, 100);
		chk(inr(v, 8'h33 + 27, 8'h33 + 38), 8'h01);
		pll_as_system_clock <= 1'b1;
		wr(fast_timer_pkg::ADDR_PLL, 8'h00);
		repeat (4) @(posedge core_clk);
		rd(fast_timer_pkg::ADDR_PLL);
		chk({7'h0, v[1]}, 8'h01);
		summarize();
	end
endmodule : fast_timer_with_pll_clock_tb_top
